//--- coo_pkg.sv
// Package of constants for the core observation outputs block.
// How it works
// (RQ1) Drive 58-bit performance event bus outward.
// (RQ2) Bits 37-38 carry SIMD renamed count.
// (RQ3) Bits 39-45 carry stall events in order.
// (RQ4) Bits 46-51 carry clock, barrier, interrupt events.
// (RQ5) Bits 52-57 carry preload engine events.
// (RQ6) Flag output is held at zero without a data engine.
// (RQ7) Media engine: flags mirror bits 27,7,4:0.
// (RQ8) Float unit only: flag bit 6 zero.
// (RQ9) Parity output, one means parity failure.
// (RQ10) Parity bits map caches, TLB, RAMs.
// (RQ11) Events registered, one cycle per occurrence.
`default_nettype none
package coo_pkg;
    localparam int EVT_W = 58;
    localparam int EVT_LO = 37;
    localparam int SIMD_POS = 37;
    localparam int STALL_POS = 39;
    localparam int STALL_N = 7;
    localparam int CLKEN_POS = 46;
    localparam int CLKEN_N = 2;
    localparam int BAR_POS = 48;
    localparam int BAR_N = 4;
    localparam int PRELOAD_POS = 52;
    localparam int PRELOAD_N = 6;
    localparam int FLAG_W = 7;
    localparam int SCR_W = 32;
    localparam int SCR_QC_POS = 27;
    localparam int SCR_IDC_POS = 7;
    localparam int SCR_EXC_W = 5;
    localparam int PAR_W = 8;
    localparam logic [EVT_W-1:0] EVT_RST = 58'h0;
    localparam logic [FLAG_W-1:0] FLAG_RST = 7'h00;
    localparam logic [PAR_W-1:0] PAR_RST = 8'h00;
    localparam logic [1:0] SIMD_MAX = 2'h2;
    localparam logic [1:0] SIMD_RST = 2'h0;
    typedef enum logic [1:0] {COO_ENG_NONE, COO_ENG_FPU, COO_ENG_MEDIA} coo_eng_e;
endpackage
`default_nettype wire

//--- coo_pulse_reg.sv
// Registered bank of single-cycle event pulses.
`default_nettype none
module coo_pulse_reg #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] event_in,
    output logic [W-1:0] pulse_out
);
    // Each input is a one-cycle strobe from the core; registering keeps pulse width at one cycle.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            pulse_out <= '0;
        else
            pulse_out <= event_in; // RQ11
    end

    a_pulse_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> pulse_out == $past(event_in)) else $error("pulse bank lost an event"); // RQ11
endmodule
`default_nettype wire

//--- coo_top.sv
// Core observation outputs: event bus upper part, exception flags, parity errors.
`default_nettype none
module coo_top #(
    parameter coo_pkg::coo_eng_e ENGINE_KIND = coo_pkg::COO_ENG_MEDIA,
    parameter bit PARITY_EN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] simd_renamed_cnt,
    input wire logic [coo_pkg::STALL_N-1:0] stall_events,
    input wire logic [coo_pkg::CLKEN_N-1:0] clk_enabled_events,
    input wire logic [coo_pkg::BAR_N-1:0] barrier_irq_events,
    input wire logic [coo_pkg::PRELOAD_N-1:0] preload_engine_events,
    input wire logic [coo_pkg::SCR_W-1:0] fp_status_control_reg,
    input wire logic [coo_pkg::PAR_W-1:0] ram_parity_error_in,
    output logic [coo_pkg::EVT_W-1:0] perf_event_bus,
    output logic [coo_pkg::FLAG_W-1:0] fp_exception_flags_out,
    output logic [coo_pkg::PAR_W-1:0] ram_parity_error_out
);
    import coo_pkg::*;

    // --------------------------------------------------------------
    // Event bus
    // --------------------------------------------------------------
    // Lower bits belong to the rest of the core and are held at zero here.
    logic [1:0] simd_d;
    logic [1:0] simd_q;
    logic [STALL_N-1:0] stall_q;
    logic [CLKEN_N-1:0] clken_q;
    logic [BAR_N-1:0] barrier_q;
    logic [PRELOAD_N-1:0] preload_q;

    // A count of three cannot occur; it is clamped so the bus never shows an illegal code.
    always_comb
    begin
        simd_d = simd_renamed_cnt;
        if (simd_renamed_cnt > SIMD_MAX)
            simd_d = SIMD_MAX; // RQ2
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            simd_q <= SIMD_RST;
        else
            simd_q <= simd_d; // RQ2
    end

    // Each event group has its own bank, so a group can move on the bus without touching the others.
    coo_pulse_reg #(.W(STALL_N)) u_stall (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(stall_events), // RQ3
        .pulse_out(stall_q)
    );

    coo_pulse_reg #(.W(CLKEN_N)) u_clken (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(clk_enabled_events), // RQ4
        .pulse_out(clken_q)
    );

    coo_pulse_reg #(.W(BAR_N)) u_barrier (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(barrier_irq_events), // RQ4
        .pulse_out(barrier_q)
    );

    coo_pulse_reg #(.W(PRELOAD_N)) u_preload (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(preload_engine_events), // RQ5
        .pulse_out(preload_q)
    );

    always_comb
    begin
        perf_event_bus = EVT_RST;
        perf_event_bus[SIMD_POS +: 2] = simd_q; // RQ1 RQ2
        perf_event_bus[STALL_POS +: STALL_N] = stall_q; // RQ1 RQ3
        perf_event_bus[CLKEN_POS +: CLKEN_N] = clken_q; // RQ1 RQ4
        perf_event_bus[BAR_POS +: BAR_N] = barrier_q; // RQ1 RQ4
        perf_event_bus[PRELOAD_POS +: PRELOAD_N] = preload_q; // RQ1 RQ5
    end

    a_simd_legal: assert property (@(posedge clk_sys) disable iff (!rst_b)
        perf_event_bus[SIMD_POS +: 2] <= SIMD_MAX) else $error("simd count above two"); // RQ2
    a_stall_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> perf_event_bus[STALL_POS +: STALL_N] == $past(stall_events)) else $error("stall map wrong"); // RQ3
    a_barrier_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> perf_event_bus[BAR_POS +: BAR_N] == $past(barrier_irq_events)) else $error("barrier map wrong"); // RQ4
    a_clken_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> perf_event_bus[CLKEN_POS +: CLKEN_N] == $past(clk_enabled_events)) else $error("clk map wrong"); // RQ4
    a_preload_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> perf_event_bus[PRELOAD_POS +: PRELOAD_N] == $past(preload_engine_events))
        else $error("preload map wrong"); // RQ5
    a_low_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        perf_event_bus[EVT_LO-1:0] == '0) else $error("low bits driven"); // RQ1
    a_simd_clamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (simd_renamed_cnt == 2'h3) |=> perf_event_bus[SIMD_POS +: 2] == SIMD_MAX) else $error("simd not clamped"); // RQ2

    // A pulse that is dropped at the input must be gone from the bus one cycle later.
    sequence s_stall_dropped;
        (stall_events != '0) ##1 (stall_events == '0);
    endsequence

    a_stall_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_stall_dropped |=> perf_event_bus[STALL_POS +: STALL_N] == '0) else $error("stall pulse stretched"); // RQ11

    sequence s_barrier_dropped;
        (barrier_irq_events != '0) ##1 (barrier_irq_events == '0);
    endsequence

    a_barrier_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_barrier_dropped |=> perf_event_bus[BAR_POS +: BAR_N] == '0) else $error("barrier pulse stretched"); // RQ11

    sequence s_preload_dropped;
        (preload_engine_events != '0) ##1 (preload_engine_events == '0);
    endsequence

    a_preload_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_preload_dropped |=> perf_event_bus[PRELOAD_POS +: PRELOAD_N] == '0)
        else $error("preload pulse stretched"); // RQ11

    // --------------------------------------------------------------
    // Exception flags
    // --------------------------------------------------------------
    // Without a data engine the port stays, tied to zero, so one netlist shape serves all options.
    logic [FLAG_W-1:0] flags_d;
    logic [FLAG_W-1:0] flags_q;

    always_comb
    begin
        flags_d = FLAG_RST;
        unique case (ENGINE_KIND)
            COO_ENG_MEDIA:
                flags_d = {fp_status_control_reg[SCR_QC_POS], fp_status_control_reg[SCR_IDC_POS],
                           fp_status_control_reg[SCR_EXC_W-1:0]}; // RQ7
            COO_ENG_FPU:
                flags_d = {1'b0, fp_status_control_reg[SCR_IDC_POS], fp_status_control_reg[SCR_EXC_W-1:0]}; // RQ8
            COO_ENG_NONE:
                flags_d = FLAG_RST; // RQ6
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            flags_q <= FLAG_RST;
        else
            flags_q <= flags_d; // RQ7 RQ8
    end

    assign fp_exception_flags_out = flags_q;

    a_flag_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ENGINE_KIND != COO_ENG_NONE) |=> fp_exception_flags_out[4:0] == $past(fp_status_control_reg[4:0]))
        else $error("flag low bits wrong"); // RQ7
    a_flag_top: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> fp_exception_flags_out[6] ==
        ((ENGINE_KIND == COO_ENG_MEDIA) && $past(fp_status_control_reg[SCR_QC_POS])))
        else $error("flag bit six wrong"); // RQ8
    a_flag_none: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ENGINE_KIND == COO_ENG_NONE) |-> fp_exception_flags_out == '0) else $error("flags without engine"); // RQ6
    a_flag_idc: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ENGINE_KIND != COO_ENG_NONE) |=> fp_exception_flags_out[5] == $past(fp_status_control_reg[SCR_IDC_POS]))
        else $error("flag bit five wrong"); // RQ7

    // --------------------------------------------------------------
    // Parity errors
    // --------------------------------------------------------------
    // Bit order 7..0: branch target cache, history buffer, itag, idata, main TLB, douter, dtag, data.
    logic [PAR_W-1:0] par_d;
    logic [PAR_W-1:0] par_pulses;

    // Without parity the strobes are gated off, so stray inputs never reach ram_parity_error_out.
    assign par_d = PARITY_EN ? ram_parity_error_in : PAR_RST; // RQ9

    coo_pulse_reg #(.W(PAR_W)) u_par (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_in(par_d), // RQ9 RQ10
        .pulse_out(par_pulses)
    );

    assign ram_parity_error_out = par_pulses;

    a_parity_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> ram_parity_error_out == (PARITY_EN ? $past(ram_parity_error_in) : PAR_RST))
        else $error("parity map wrong"); // RQ9

    sequence s_parity_dropped;
        (ram_parity_error_in != '0) ##1 (ram_parity_error_in == '0);
    endsequence

    a_parity_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_parity_dropped |=> ram_parity_error_out == '0) else $error("parity pulse stretched"); // RQ11
    a_parity_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!PARITY_EN) |-> ram_parity_error_out == '0) else $error("parity without option"); // RQ9

    for (genvar b = 0; b < PAR_W; b++)
    begin : g_par_bit
        a_parity_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
            (PARITY_EN && ram_parity_error_in[b]) |=> ram_parity_error_out[b]) else $error("parity bit lost"); // RQ10
    end

    // --------------------------------------------------------------
    // Reset checks
    // --------------------------------------------------------------
    a_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> (perf_event_bus == EVT_RST) && (ram_parity_error_out == PAR_RST))
        else $error("outputs not quiet after reset"); // RQ11
endmodule
`default_nettype wire

//--- coo_event_mon.sv
// Downstream event counter model that samples event bus bits 57:39.
`default_nettype none
module coo_event_mon (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [57:0] perf_event_bus,
    output logic [7:0] pulse_cnt_q
);
    timeunit 1ns;
    timeprecision 100ps;
    // The counter samples the bus directly, so a pulse stretched by the block would be counted twice.
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            pulse_cnt_q <= 8'h00;
        else if (|perf_event_bus[57:39])
            pulse_cnt_q <= pulse_cnt_q + 8'h01;
endmodule
`default_nettype wire

//--- coo_top_tb.sv
// Self-checking bench for the core observation outputs block.
`default_nettype none
module coo_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import coo_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] simd = 2'h3;
    logic [18:0] ev = 19'h7FFFF;
    logic [31:0] scr = 32'hFFFFFFFF;
    logic [7:0] par = 8'hFF;
    logic [57:0] bus_m;
    logic [6:0] flg_m, flg_f, flg_n;
    logic [7:0] par_m, par_f, cnt;
    int num_errors = 0;
    int total_checks = 0;
    always #4 clk_sys = ~clk_sys;
    coo_top #(.ENGINE_KIND(COO_ENG_MEDIA), .PARITY_EN(1'b1)) i_coo_top (.clk_sys, .rst_b, .simd_renamed_cnt(simd),
        .stall_events(ev[6:0]), .clk_enabled_events(ev[8:7]), .barrier_irq_events(ev[12:9]),
        .preload_engine_events(ev[18:13]), .fp_status_control_reg(scr), .ram_parity_error_in(par),
        .perf_event_bus(bus_m), .fp_exception_flags_out(flg_m), .ram_parity_error_out(par_m));
    coo_top #(.ENGINE_KIND(COO_ENG_FPU), .PARITY_EN(1'b0)) i_coo_top_fpu (.clk_sys, .rst_b, .simd_renamed_cnt(simd),
        .stall_events(ev[6:0]), .clk_enabled_events(ev[8:7]), .barrier_irq_events(ev[12:9]),
        .preload_engine_events(ev[18:13]), .fp_status_control_reg(scr), .ram_parity_error_in(par),
        .perf_event_bus(), .fp_exception_flags_out(flg_f), .ram_parity_error_out(par_f));
    coo_top #(.ENGINE_KIND(COO_ENG_NONE), .PARITY_EN(1'b1)) i_coo_top_none (.clk_sys, .rst_b,
        .simd_renamed_cnt(simd), .stall_events(ev[6:0]), .clk_enabled_events(ev[8:7]),
        .barrier_irq_events(ev[12:9]), .preload_engine_events(ev[18:13]), .fp_status_control_reg(scr),
        .ram_parity_error_in(par), .perf_event_bus(), .fp_exception_flags_out(flg_n), .ram_parity_error_out());
    coo_event_mon i_coo_event_mon (.clk_sys, .rst_b, .perf_event_bus(bus_m), .pulse_cnt_q(cnt));
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Inputs change just after an edge and are held for exactly one cycle.
    task automatic go(input logic [1:0] s, input logic [18:0] e, input logic [31:0] c, input logic [7:0] p);
        simd = s;
        ev = e;
        scr = c;
        par = p;
        @(posedge clk_sys) #1;
        check(bus_m, {e, ((s == 2'h3) ? 2'h2 : s), 37'h0});
        check(flg_m, {c[27], c[7], c[4:0]});
        check(flg_f, {1'b0, c[7], c[4:0]});
        check(flg_n, 7'h00);
        check(par_m, p);
        check(par_f, 8'h00);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        check({bus_m, flg_m, par_m}, 80'h0);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 19; i++)
            go(i[1:0], 19'h1 << i, (i[0] ? 32'h08000000 : 32'h00000080) | 32'hF000FF00 | i, 8'h01 << (i % 8));
        go(2'h0, 19'h0, 32'h0, 8'h00);
        check(cnt, 8'h13);
        complete_run;
    end
    initial
    begin
        #2000;
        num_errors++;
        complete_run;
    end
endmodule
`default_nettype wire
